// >>> rtl/psf_protect.sv
// Fault protection and report logic for a six- or seven-switch power stage.
// Summary of operation
// - A qualified supply-low flag forces all gates off and raises the fault report.
// - Supply-low flags shorter than the glitch filter time are ignored.
// - After a supply-low trip gates stay off until the release flag returns.
// - Supply-low protection also acts while the supply ramps up or down.
// - During a supply-low trip gates stay off even when commanded on.
// - Overheat disables gates and ignores the command while the condition persists.
// - The fault report stays asserted for as long as overheat is active.
// - Overheat recovery needs temperature released and command off; resume at next on.
// - Gate commands are active low: high means off, low means on.
// - A short-circuit flag starts an immediate controlled shutdown and fault report.
// - Short-circuit shutdown passes through a soft-off state before the off state.
// - After short-circuit shutdown a timer holds the fault report for 1.8 ms.
// - An off-then-on command within the restart block interval keeps the switch off.
// - The fault report is asserted while any protection function is active.
`timescale 1ns/10ps
module psf_protect #(
  parameter int unsigned SWITCHES = psf_pkg::SWITCHES,
  parameter int unsigned GLITCH_CYCLES = psf_pkg::GLITCH_CYCLES,
  parameter int unsigned FAULT_HOLD_CYCLES = psf_pkg::FAULT_HOLD_CYCLES,
  parameter int unsigned RESTART_BLOCK_CYCLES = psf_pkg::RESTART_BLOCK_CYCLES,
  parameter int unsigned SOFT_OFF_CYCLES = psf_pkg::SOFT_OFF_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [SWITCHES-1:0] gate_cmd_n_i,
  input wire logic supply_low_protect_i,
  input wire logic supply_low_release_level_i,
  input wire logic overheat_protect_i,
  input wire logic overheat_release_level_i,
  input wire logic short_circuit_protect_i,
  output logic [SWITCHES-1:0] gate_on_o,
  output logic [SWITCHES-1:0] gate_soft_o,
  output logic fault_report_n_o
);
  import psf_pkg::*;

  initial begin
    if (SWITCHES < 1 || GLITCH_CYCLES < 1 || FAULT_HOLD_CYCLES < 1 ||
        RESTART_BLOCK_CYCLES < 1 || SOFT_OFF_CYCLES < 1 ||
        FAULT_HOLD_CYCLES >= (1 << CNT_W) || RESTART_BLOCK_CYCLES >= (1 << CNT_W) ||
        GLITCH_CYCLES >= (1 << CNT_W) || SOFT_OFF_CYCLES >= (1 << CNT_W)) begin
      $error("psf_protect: parameter out of range");
    end
  end

  // Three-stage synchronisers; the first stage feeds only the second.
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic [4:0] flt;
  logic [SWITCHES-1:0] cmd1;
  logic [SWITCHES-1:0] cmd2;
  logic [SWITCHES-1:0] cmd3;
  logic [SWITCHES-1:0] cmd_off;

  always_ff @(posedge clock_i) begin
    sync1 <= {short_circuit_protect_i, overheat_release_level_i, overheat_protect_i,
              supply_low_release_level_i, supply_low_protect_i};
    sync2 <= sync1;
    sync3 <= sync2;
    cmd1 <= gate_cmd_n_i;
    cmd2 <= cmd1;
    cmd3 <= cmd2;
  end

  // A change is accepted only once the second and third stages agree.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      flt <= 5'h00;
      cmd_off <= '1;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (sync2[i] == sync3[i]) begin
          flt[i] <= sync3[i];
        end
      end
      for (int i = 0; i < SWITCHES; i++) begin
        if (cmd2[i] == cmd3[i]) begin
          cmd_off[i] <= cmd3[i];
        end
      end
    end
  end

  wire uv_raw = flt[0];
  wire uv_rel = flt[1];
  wire ot_raw = flt[2];
  wire ot_rel = flt[3];
  wire sc_raw = flt[4];

  // Supply-low glitch filter and hysteresis latch.
  logic [CNT_W-1:0] uv_cnt;
  logic uv_trip;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      uv_cnt <= '0;
      uv_trip <= 1'b1; // Held tripped from reset so a ramping supply is covered.
    end else begin
      if (!uv_raw) begin
        uv_cnt <= '0;
      end else if (uv_cnt < CNT_W'(GLITCH_CYCLES)) begin
        uv_cnt <= uv_cnt + 1'b1;
      end
      if (uv_raw && uv_cnt >= CNT_W'(GLITCH_CYCLES - 1)) begin
        uv_trip <= 1'b1;
      end else if (uv_trip && !uv_raw && uv_rel) begin
        uv_trip <= 1'b0;
      end
    end
  end

  // Overheat latch: released only with temperature low and every command off.
  logic ot_trip;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ot_trip <= 1'b0;
    end else if (ot_raw) begin
      ot_trip <= 1'b1;
    end else if (ot_trip && ot_rel && (&cmd_off)) begin
      ot_trip <= 1'b0;
    end
  end

  // Short-circuit sequence: soft turn-off, then off with fault hold and restart block.
  psf_sc_state_t sc_state;
  logic [CNT_W-1:0] soft_cnt;
  logic [CNT_W-1:0] hold_cnt;
  logic [CNT_W-1:0] block_cnt;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sc_state <= PSF_RUN;
      soft_cnt <= '0;
      hold_cnt <= '0;
      block_cnt <= '0;
    end else begin
      unique case (sc_state)
        PSF_RUN: begin
          if (sc_raw) begin
            sc_state <= PSF_SOFT;
            soft_cnt <= '0;
          end
        end
        PSF_SOFT: begin
          if (soft_cnt >= CNT_W'(SOFT_OFF_CYCLES - 1)) begin
            sc_state <= PSF_OFF;
            hold_cnt <= CNT_W'(FAULT_HOLD_CYCLES);
            block_cnt <= CNT_W'(RESTART_BLOCK_CYCLES);
          end else begin
            soft_cnt <= soft_cnt + 1'b1;
          end
        end
        PSF_OFF: begin
          if (hold_cnt != '0) begin
            hold_cnt <= hold_cnt - 1'b1;
          end
          if (block_cnt != '0) begin
            block_cnt <= block_cnt - 1'b1;
          end
          if (hold_cnt <= CNT_W'(1) && block_cnt <= CNT_W'(1) && !sc_raw) begin
            sc_state <= PSF_RUN;
          end
        end
        default: sc_state <= PSF_OFF;
      endcase
    end
  end

  wire sc_active = (sc_state != PSF_RUN);
  // Raw overheat and short-circuit flags block the gates at once, before their latches settle.
  wire any_trip = uv_trip || ot_raw || ot_trip || sc_active || sc_raw;

  // Outputs come straight from flip-flops; a trip wins over any on command.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      gate_on_o <= '0;
      gate_soft_o <= '0;
      fault_report_n_o <= 1'b1;
    end else begin
      gate_on_o <= any_trip ? '0 : ~cmd_off;
      gate_soft_o <= (sc_state == PSF_SOFT) ? ~cmd_off : '0;
      fault_report_n_o <= !any_trip;
    end
  end

  a_uv_gates_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    uv_trip |=> (gate_on_o == '0) && !fault_report_n_o)
    else $error("gate on or no fault during supply-low trip");

  a_uv_filter: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(uv_raw) && !uv_trip |=> !uv_trip)
    else $error("supply-low tripped before filter time");

  a_uv_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    uv_trip && !uv_rel |=> uv_trip)
    else $error("supply-low released without release level");

  a_ot_fault: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ot_raw |=> !fault_report_n_o && (gate_on_o == '0))
    else $error("fault not held during overheat");

  a_ot_release: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ot_trip && !(&cmd_off) |=> ot_trip)
    else $error("overheat released with command on");

  sequence s_sc_hit;
    sc_state == PSF_RUN && sc_raw;
  endsequence

  sequence s_soft_phase;
    sc_state == PSF_SOFT [*1];
  endsequence

  a_sc_soft_first: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_sc_hit |=> s_soft_phase ##0 !fault_report_n_o)
    else $error("short circuit did not enter soft off");

  a_sc_block: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sc_state == PSF_OFF && block_cnt > CNT_W'(1) |=> gate_on_o == '0)
    else $error("switch restarted within block interval");

  a_any_fault: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    any_trip |=> !fault_report_n_o)
    else $error("fault report missing while protection active");

  a_fault_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !any_trip |=> fault_report_n_o)
    else $error("fault report raised with no protection active");

  a_idle_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !any_trip |=> gate_on_o == ~$past(cmd_off))
    else $error("gate drive does not follow the command");

  a_reset_quiet: assert property (@(posedge clock_i)
    !rst_n_i |=> (gate_on_o == '0) && (gate_soft_o == '0) && fault_report_n_o)
    else $error("outputs not quiet during reset");

  a_uv_trip_set: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    uv_raw && uv_cnt >= CNT_W'(GLITCH_CYCLES - 1) |=> uv_trip)
    else $error("supply-low not tripped after filter time");

  a_uv_release: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    uv_trip && !uv_raw && uv_rel |=> !uv_trip)
    else $error("supply-low not released at release level");

  a_ot_gate_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ot_raw || ot_trip |=> gate_on_o == '0)
    else $error("gate on during overheat");

  a_ot_release_ok: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ot_trip && !ot_raw && ot_rel && (&cmd_off) |=> !ot_trip)
    else $error("overheat not released with command off");

  a_sc_immediate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sc_raw |=> (gate_on_o == '0) && !fault_report_n_o)
    else $error("short circuit did not block the gate at once");

  a_off_stays: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sc_state == PSF_OFF && sc_raw |=> sc_state != PSF_RUN)
    else $error("short-circuit sequence left while flag active");

  a_sc_soft_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sc_state == PSF_SOFT |=> gate_on_o == '0)
    else $error("gate on during soft turn-off");

  a_soft_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sc_state != PSF_SOFT |=> gate_soft_o == '0)
    else $error("soft drive active outside soft turn-off");

  a_soft_len: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sc_state == PSF_SOFT && soft_cnt < CNT_W'(SOFT_OFF_CYCLES - 1) |=> sc_state == PSF_SOFT)
    else $error("soft turn-off ended early");

  // The soft phase ends once its counter reaches the last cycle.
  sequence s_soft_done;
    sc_state == PSF_SOFT && soft_cnt >= CNT_W'(SOFT_OFF_CYCLES - 1);
  endsequence

  a_soft_to_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_soft_done |=> sc_state == PSF_OFF && hold_cnt == CNT_W'(FAULT_HOLD_CYCLES))
    else $error("fault hold timer not started after soft turn-off");

  a_sc_hold_fault: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sc_state == PSF_OFF && hold_cnt > CNT_W'(1) |=> !fault_report_n_o)
    else $error("fault report dropped during fault hold");

  a_block_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sc_state == PSF_OFF && block_cnt > CNT_W'(1) |=> sc_state == PSF_OFF)
    else $error("short-circuit off state left within block interval");

  a_sc_off_exit: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sc_state == PSF_OFF && hold_cnt <= CNT_W'(1) && block_cnt <= CNT_W'(1) && !sc_raw
    |=> sc_state == PSF_RUN)
    else $error("short-circuit off state not left after timers");

endmodule : psf_protect

// >>> rtl/psf_pkg.sv
// Package with constants and types for the power stage fault protection block.
package psf_pkg;
  localparam int unsigned CLOCK_HZ = 25000000;
  localparam int unsigned GLITCH_FILTER_NS = 10000;
  localparam int unsigned FAULT_HOLD_US = 1800;
  localparam int unsigned RESTART_BLOCK_US = 1800;
  localparam int unsigned SOFT_OFF_NS = 2000;
  localparam int unsigned GLITCH_CYCLES = GLITCH_FILTER_NS / (1000000000 / CLOCK_HZ);
  localparam int unsigned FAULT_HOLD_CYCLES = FAULT_HOLD_US * (CLOCK_HZ / 1000000);
  localparam int unsigned RESTART_BLOCK_CYCLES = RESTART_BLOCK_US * (CLOCK_HZ / 1000000);
  localparam int unsigned SOFT_OFF_CYCLES = SOFT_OFF_NS / (1000000000 / CLOCK_HZ);
  localparam int unsigned SWITCHES = 7;
  localparam int unsigned CNT_W = 20;
  typedef enum logic [1:0] {
    PSF_RUN = 2'b00,
    PSF_SOFT = 2'b01,
    PSF_OFF = 2'b11
  } psf_sc_state_t;
endpackage : psf_pkg

// >>> tb/psf_ctrl_model.sv
// Behavioural system controller that drives the gate commands and watches the fault report.
`timescale 1ns/10ps
module psf_ctrl_model (
  input wire logic clock_i,
  input wire logic [psf_pkg::SWITCHES-1:0] want_on_i,
  input wire logic halt_en_i,
  input wire logic fault_report_n_i,
  output logic [psf_pkg::SWITCHES-1:0] gate_cmd_n_o
);
  import psf_pkg::*;
  initial gate_cmd_n_o = '1;
  // Halting stays off while the supply ramps, so the power-up fault is only waited out.
  always @(posedge clock_i) begin
    if (halt_en_i && fault_report_n_i !== 1'b1) begin
      gate_cmd_n_o <= '1;
    end else begin
      // The top switch is an unused phase, so its command is parked high.
      gate_cmd_n_o <= ~(want_on_i & 7'h3F);
    end
  end
endmodule : psf_ctrl_model

// >>> tb/psf_protect_tb.sv
// Self-checking testbench for the power stage fault protection block.
`timescale 1ns/10ps
module psf_protect_tb;
  import psf_pkg::*;
  logic clock, rst_n, halt_en, sup_low, sup_rel, oh, oh_rel, sc, fault_n;
  logic [SWITCHES-1:0] want_on, cmd_n, gate_on, gate_soft;
  int mismatches = 0;
  int samples_checked = 0;
  psf_ctrl_model u_psf_ctrl_model (.clock_i(clock), .want_on_i(want_on), .halt_en_i(halt_en),
    .fault_report_n_i(fault_n), .gate_cmd_n_o(cmd_n));
  psf_protect #(.GLITCH_CYCLES(4), .FAULT_HOLD_CYCLES(20), .RESTART_BLOCK_CYCLES(20),
    .SOFT_OFF_CYCLES(3)) u_psf_protect (.clock_i(clock), .rst_n_i(rst_n),
    .gate_cmd_n_i(cmd_n), .supply_low_protect_i(sup_low),
    .supply_low_release_level_i(sup_rel), .overheat_protect_i(oh),
    .overheat_release_level_i(oh_rel), .short_circuit_protect_i(sc),
    .gate_on_o(gate_on), .gate_soft_o(gate_soft), .fault_report_n_o(fault_n));
  always #20 clock = ~clock;
  task report_and_stop;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task check_vec(input logic [SWITCHES-1:0] got, input logic [SWITCHES-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t gate vector %h expected %h", $time, got, exp);
    end
  endtask : check_vec
  task check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t fault report %b expected %b", $time, got, exp);
    end
  endtask : check_bit
  // Bounded wait so a stuck gate shows up as a mismatch, not a hang.
  task wait_gate(input logic [SWITCHES-1:0] exp, input int max);
    int i;
    i = 0;
    while (gate_on !== exp && i < max) begin
      cyc(1);
      i++;
    end
  endtask : wait_gate
  task t_powerup;
    cyc(2);
    check_bit(fault_n, 1'b0);
    check_vec(gate_on, 7'h00);
    sup_rel = 1'b1;
    wait_gate(7'h3F, 20);
    check_vec(gate_on, 7'h3F);
    check_bit(fault_n, 1'b1);
  endtask : t_powerup
  task t_glitch;
    sup_low = 1'b1;
    cyc(2);
    sup_low = 1'b0;
    cyc(10);
    check_vec(gate_on, 7'h3F);
    check_bit(fault_n, 1'b1);
  endtask : t_glitch
  task t_supply_low;
    sup_low = 1'b1;
    sup_rel = 1'b0;
    wait_gate(7'h00, 20);
    check_vec(gate_on, 7'h00);
    check_bit(fault_n, 1'b0);
    sup_low = 1'b0;
    cyc(10);
    check_vec(gate_on, 7'h00);
    sup_rel = 1'b1;
    wait_gate(7'h3F, 20);
    check_vec(gate_on, 7'h3F);
  endtask : t_supply_low
  task t_overheat;
    oh = 1'b1;
    oh_rel = 1'b0;
    wait_gate(7'h00, 20);
    check_vec(gate_on, 7'h00);
    repeat (8) begin
      cyc(1);
      check_bit(fault_n, 1'b0);
    end
    oh = 1'b0;
    oh_rel = 1'b1;
    cyc(10);
    check_vec(gate_on, 7'h00);
    halt_en = 1'b1;
    wait_gate(7'h3F, 40);
    check_vec(gate_on, 7'h3F);
    check_bit(fault_n, 1'b1);
    halt_en = 1'b0;
  endtask : t_overheat
  task t_short;
    int i;
    sc = 1'b1;
    for (i = 0; i < 20 && gate_soft !== 7'h3F; i++) cyc(1);
    check_vec(gate_soft, 7'h3F);
    check_vec(gate_on, 7'h00);
    sc = 1'b0;
    for (i = 0; i < 20 && gate_soft !== 7'h00; i++) cyc(1);
    check_vec(gate_on, 7'h00);
    check_bit(fault_n, 1'b0);
    want_on = 7'h00;
    cyc(3);
    want_on = 7'h3F;
    cyc(5);
    check_vec(gate_on, 7'h00);
    check_bit(fault_n, 1'b0);
    wait_gate(7'h3F, 100);
    check_vec(gate_on, 7'h3F);
    check_bit(fault_n, 1'b1);
  endtask : t_short
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    want_on = 7'h3F;
    halt_en = 1'b0;
    sup_low = 1'b0;
    sup_rel = 1'b0;
    oh = 1'b0;
    oh_rel = 1'b1;
    sc = 1'b0;
    cyc(3);
    rst_n = 1'b1;
    t_powerup();
    t_glitch();
    t_supply_low();
    t_overheat();
    t_short();
    report_and_stop();
  end
  initial begin
    #800000;
    mismatches++;
    report_and_stop();
  end
endmodule : psf_protect_tb
